// ===== gia_defs.svh
// offsets, field positions, reset values and codes of the interrupt aggregator
`ifndef GIA_DEFS_SVH
`define GIA_DEFS_SVH
// register indices; byte address is four times the index
`define GIA_IDX_STAT1  6'h19
`define GIA_IDX_STAT2  6'h1A
`define GIA_IDX_PSTAT  6'h1E
`define GIA_IDX_MASK1  6'h21
`define GIA_IDX_MASK2  6'h22
`define GIA_IDX_PMASK  6'h26
// register and field geometry
`define GIA_REG_W      16
`define GIA_DATA_W     32
`define GIA_IDX_W      6
`define GIA_ADDR_MIN   8
`define GIA_IDX_LO     2
`define GIA_RTC_HI     7
`define GIA_RTC_LO     5
`define GIA_RTC_N      3
`define GIA_CNV_HI     8
`define GIA_CNV_LO     4
`define GIA_CNV_N      5
`define GIA_PIN_DEF    13
// reset values
`define GIA_MASK_RST   16'h0000
// AXI4-Lite response codes
`define GIA_RESP_OKAY  2'h0
`define GIA_RESP_SLV   2'h2
`endif

// ===== gia_pkg.sv
// types shared by the interrupt aggregator
package gia_pkg;
  `include "gia_defs.svh"

  // complete state of the aggregator, registered as one word
  typedef struct packed {
    logic [`GIA_REG_W-1:0]  pin_flag;
    logic [`GIA_CNV_N-1:0]  cnv_flag;
    logic [`GIA_RTC_N-1:0]  rtc_flag;
    logic [`GIA_REG_W-1:0]  pin_mask;
    logic [`GIA_CNV_N-1:0]  cnv_mask;
    logic [`GIA_RTC_N-1:0]  rtc_mask;
    logic [`GIA_CNV_N-1:0]  cnv_prev;
    logic [`GIA_RTC_N-1:0]  rtc_prev;
    logic                   aw_hold;
    logic [`GIA_IDX_W-1:0]  aw_idx;
    logic                   aw_ok;
    logic                   w_hold;
    logic [`GIA_REG_W-1:0]  w_data;
    logic [1:0]             w_strb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [`GIA_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
    logic                   pin_irq;
    logic                   cnv_irq;
    logic                   rtc_irq;
    logic                   irq;
  } gia_state_t;
endpackage

// ===== gia_irq_agg.sv
// interrupt aggregator for pin, converter and clock flags behind AXI4-Lite
// Behaviour
// [RULE_01] thirteen pin sources form one pin interrupt
// [RULE_02] pin n flag at status bit n
// [RULE_03] pin trigger condition comes from pin logic
// [RULE_04] status flags clear when their register reads
// [RULE_05] pin mask bits 12:0, one masks
// [RULE_06] every mask bit resets to zero
// [RULE_07] converter flags in bits 8:4 of status two
// [RULE_08] data ready, comparators four..one, rising edge
// [RULE_09] mask two bits 8:4 mask converter flags
// [RULE_10] clock flags in bits 7:5 of status one
// [RULE_11] periodic, second, alarm flags on rising edge
// [RULE_12] mask one bits 7:5 mask clock flags
// [RULE_13] group interrupt high while unmasked flag set
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "gia_defs.svh"

module gia_irq_agg
  import gia_pkg::*;
#(
  parameter int NPINS  = `GIA_PIN_DEF, // pin sources
  parameter int ADDR_W = `GIA_ADDR_MIN // byte address width
) (
  input  wire logic              clk,                 // 100 MHz clock
  input  wire logic              nrst,                // async reset
  input  wire logic [NPINS-1:0]  pin_trig,            // qualified pin events
  input  wire logic [4:0]        conv_evt,            // ready, comp 4..1
  input  wire logic [2:0]        rtc_evt,             // periodic, second, alarm
  input  wire logic [ADDR_W-1:0] awaddr,              // write address
  input  wire logic [2:0]        awprot,              // unused
  input  wire logic              awvalid,             // write address valid
  output logic                   awready,             // write address ready
  input  wire logic [31:0]       wdata,               // write data
  input  wire logic [3:0]        wstrb,               // byte strobes
  input  wire logic              wvalid,              // write data valid
  output logic                   wready,              // write data ready
  output logic [1:0]             bresp,               // write response
  output logic                   bvalid,              // response valid
  input  wire logic              bready,              // response ready
  input  wire logic [ADDR_W-1:0] araddr,              // read address
  input  wire logic [2:0]        arprot,              // unused
  input  wire logic              arvalid,             // read address valid
  output logic                   arready,             // read address ready
  output logic [31:0]            rdata,               // read data
  output logic [1:0]             rresp,               // read response
  output logic                   rvalid,              // read data valid
  input  wire logic              rready,              // read data ready
  output logic                   pin_group_irq,       // pin group interrupt
  output logic                   converter_group_irq, // converter group
  output logic                   rtc_group_irq,       // clock group
  output logic                   irq                  // any group
);

  localparam logic [`GIA_REG_W-1:0] PIN_VALID =
    `GIA_REG_W'((33'h1 << NPINS) - 33'h1);

  // refuse geometries the register layout cannot hold
  if (NPINS < 1 || NPINS > `GIA_REG_W) begin : g_chk_pins
    $error("pin count must fit one register");
  end
  if (ADDR_W < `GIA_ADDR_MIN) begin : g_chk_addr
    $error("address too narrow for the register map");
  end

  gia_state_t s_r;
  gia_state_t s_nxt;

  // word index of a byte address
  function automatic logic [`GIA_IDX_W-1:0] f_idx(input logic [ADDR_W-1:0] a);
    f_idx = a[`GIA_IDX_LO +: `GIA_IDX_W];
  endfunction

  // aligned, in range and naming a register
  function automatic logic f_ok(input logic [ADDR_W-1:0] a);
    logic [`GIA_IDX_W-1:0] i;
    logic                  hit;
    i   = f_idx(a);
    hit = (i == `GIA_IDX_STAT1) || (i == `GIA_IDX_STAT2) ||
          (i == `GIA_IDX_PSTAT) || (i == `GIA_IDX_MASK1) ||
          (i == `GIA_IDX_MASK2) || (i == `GIA_IDX_PMASK);
    f_ok = hit && (a[`GIA_IDX_LO-1:0] == '0) &&
           ((a >> (`GIA_IDX_LO + `GIA_IDX_W)) == '0);
  endfunction

  // byte-lane merge of new data into an old register value
  function automatic logic [`GIA_REG_W-1:0] f_merge(
    input logic [`GIA_REG_W-1:0] old,
    input logic [`GIA_REG_W-1:0] dat,
    input logic [1:0]            stb
  );
    f_merge = old;
    if (stb[0]) begin
      f_merge[7:0] = dat[7:0];
    end
    if (stb[1]) begin
      f_merge[15:8] = dat[15:8];
    end
  endfunction

  // register image as software sees it; unused bits read zero
  function automatic logic [`GIA_REG_W-1:0] f_read(
    input logic [`GIA_IDX_W-1:0] i,
    input gia_state_t            s
  );
    f_read = '0;
    case (i)
      `GIA_IDX_STAT1: f_read[`GIA_RTC_HI:`GIA_RTC_LO] = s.rtc_flag;
      `GIA_IDX_STAT2: f_read[`GIA_CNV_HI:`GIA_CNV_LO] = s.cnv_flag;
      // [RULE_02] pin n at bit n
      `GIA_IDX_PSTAT: f_read = s.pin_flag;
      `GIA_IDX_MASK1: f_read[`GIA_RTC_HI:`GIA_RTC_LO] = s.rtc_mask;
      `GIA_IDX_MASK2: f_read[`GIA_CNV_HI:`GIA_CNV_LO] = s.cnv_mask;
      `GIA_IDX_PMASK: f_read = s.pin_mask;
      default:        f_read = '0;
    endcase
  endfunction

  // next state: events, bus writes, bus reads, interrupt outputs
  always_comb begin
    logic [`GIA_REG_W-1:0] p_set;
    logic [`GIA_REG_W-1:0] p_clr;
    logic [`GIA_CNV_N-1:0] c_set;
    logic [`GIA_CNV_N-1:0] c_clr;
    logic [`GIA_RTC_N-1:0] r_set;
    logic [`GIA_RTC_N-1:0] r_clr;
    logic [`GIA_REG_W-1:0] wd;
    logic [`GIA_REG_W-1:0] mg;
    logic [`GIA_IDX_W-1:0] ri;
    p_set = '0;
    p_clr = '0;
    c_set = '0;
    c_clr = '0;
    r_set = '0;
    r_clr = '0;
    wd    = '0;
    mg    = '0;
    ri    = '0;
    s_nxt = s_r;

    // [RULE_03] pin triggers arrive qualified
    // pin logic picks edge or level; each high cycle is an event
    p_set = `GIA_REG_W'(pin_trig) & PIN_VALID;
    // [RULE_08] converter rising edges
    c_set = conv_evt & ~s_r.cnv_prev;
    // [RULE_11] clock rising edges
    r_set = rtc_evt & ~s_r.rtc_prev;
    s_nxt.cnv_prev = conv_evt;
    s_nxt.rtc_prev = rtc_evt;

    // address and data are taken apart, in either order
    if (awvalid && s_r.awready) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_idx  = f_idx(awaddr);
      s_nxt.aw_ok   = f_ok(awaddr);
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.w_data = wdata[`GIA_REG_W-1:0];
      s_nxt.w_strb = wstrb[1:0];
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // perform the write once both halves are held
    if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = s_r.aw_ok ? `GIA_RESP_OKAY : `GIA_RESP_SLV;
      // unstrobed lanes clear nothing on the status registers
      wd = f_merge('0, s_r.w_data, s_r.w_strb);
      if (s_r.aw_ok) begin
        case (s_r.aw_idx)
          `GIA_IDX_STAT1: r_clr = wd[`GIA_RTC_HI:`GIA_RTC_LO];
          `GIA_IDX_STAT2: c_clr = wd[`GIA_CNV_HI:`GIA_CNV_LO];
          `GIA_IDX_PSTAT: p_clr = wd;
          `GIA_IDX_MASK1: begin
            mg = f_merge(f_read(`GIA_IDX_MASK1, s_r), s_r.w_data, s_r.w_strb);
            // [RULE_12] clock mask bits 7:5
            s_nxt.rtc_mask = mg[`GIA_RTC_HI:`GIA_RTC_LO];
          end
          `GIA_IDX_MASK2: begin
            mg = f_merge(f_read(`GIA_IDX_MASK2, s_r), s_r.w_data, s_r.w_strb);
            // [RULE_09] converter mask bits 8:4
            s_nxt.cnv_mask = mg[`GIA_CNV_HI:`GIA_CNV_LO];
          end
          `GIA_IDX_PMASK: begin
            mg = f_merge(s_r.pin_mask, s_r.w_data, s_r.w_strb);
            // [RULE_05] pin mask bits 12:0
            s_nxt.pin_mask = mg & PIN_VALID;
          end
          default: ;
        endcase
      end
    end

    // read path: one read at a time, data latched at acceptance
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      ri           = f_idx(araddr);
      s_nxt.rvalid = 1'b1;
      if (f_ok(araddr)) begin
        s_nxt.rresp = `GIA_RESP_OKAY;
        s_nxt.rdata = `GIA_DATA_W'(f_read(ri, s_r));
        // [RULE_04] clear on read
        // the image is taken before the clear, so nothing is lost
        case (ri)
          `GIA_IDX_STAT1: r_clr = r_clr | s_r.rtc_flag;
          `GIA_IDX_STAT2: c_clr = c_clr | s_r.cnv_flag;
          `GIA_IDX_PSTAT: p_clr = p_clr | s_r.pin_flag;
          default: ;
        endcase
      end else begin
        s_nxt.rresp = `GIA_RESP_SLV;
        s_nxt.rdata = '0;
      end
    end

    // [RULE_01] sticky pin flags, set beats clear
    s_nxt.pin_flag = ((s_r.pin_flag & ~p_clr) | p_set) & PIN_VALID;
    // [RULE_07] sticky converter flags
    s_nxt.cnv_flag = (s_r.cnv_flag & ~c_clr) | c_set;
    // [RULE_10] sticky clock flags
    s_nxt.rtc_flag = (s_r.rtc_flag & ~r_clr) | r_set;

    // ready flags follow the held halves and pending answers
    s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_hold && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    // [RULE_13] group interrupts from unmasked flags
    // taken from next state so outputs track the flags exactly
    s_nxt.pin_irq = |(s_nxt.pin_flag & ~s_nxt.pin_mask);
    s_nxt.cnv_irq = |(s_nxt.cnv_flag & ~s_nxt.cnv_mask);
    s_nxt.rtc_irq = |(s_nxt.rtc_flag & ~s_nxt.rtc_mask);
    s_nxt.irq     = s_nxt.pin_irq || s_nxt.cnv_irq || s_nxt.rtc_irq;
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // [RULE_06] masks clear at reset
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign awready             = s_r.awready;
  assign wready              = s_r.wready;
  assign bvalid              = s_r.bvalid;
  assign bresp               = s_r.bresp;
  assign arready             = s_r.arready;
  assign rvalid              = s_r.rvalid;
  assign rdata               = s_r.rdata;
  assign rresp               = s_r.rresp;
  assign pin_group_irq       = s_r.pin_irq;
  assign converter_group_irq = s_r.cnv_irq;
  assign rtc_group_irq       = s_r.rtc_irq;
  assign irq                 = s_r.irq;

  // checks on the driven state
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // read acceptance of the pin status register
  logic rd_pin;
  assign rd_pin = arvalid && s_r.arready && f_ok(araddr) &&
                  (f_idx(araddr) == `GIA_IDX_PSTAT);

  // rising edges seen this cycle; named so the checks can look back at them
  logic [`GIA_CNV_N-1:0] cnv_rise;
  logic [`GIA_RTC_N-1:0] rtc_rise;
  assign cnv_rise = conv_evt & ~s_r.cnv_prev;
  assign rtc_rise = rtc_evt & ~s_r.rtc_prev;

  // [RULE_02] pin flag follows its trigger
  AST_PIN_SET: assert property ( // [RULE_02]
    (|(pin_trig)) |=>
      ((s_r.pin_flag & `GIA_REG_W'($past(pin_trig))) ==
       (`GIA_REG_W'($past(pin_trig)) & PIN_VALID)))
    else $error("pin trigger did not set its flag");

  // [RULE_03] no pin flag rises without its trigger
  AST_PIN_CAUSE: assert property ( // [RULE_03]
    ((s_r.pin_flag & ~$past(s_r.pin_flag)) &
     ~`GIA_REG_W'($past(pin_trig))) == '0)
    else $error("pin flag rose without trigger");

  // [RULE_04] read returns the flags, then clears them
  AST_RD_CLR: assert property ( // [RULE_04]
    (rd_pin && pin_trig == '0) |=>
      (s_r.rvalid && s_r.rdata[`GIA_REG_W-1:0] == $past(s_r.pin_flag) &&
       s_r.pin_flag == '0))
    else $error("pin status read wrong or not cleared");

  // [RULE_06] masks zero at the first edge after reset
  AST_MASK_RST: assert property ( // [RULE_06]
    $rose(nrst) |-> (s_r.pin_mask == `GIA_MASK_RST &&
                     s_r.cnv_mask == '0 && s_r.rtc_mask == '0))
    else $error("mask not zero after reset");

  // [RULE_08] data ready edge sets bit 8
  AST_CNV_EDGE: assert property ( // [RULE_08]
    (conv_evt[4] && !s_r.cnv_prev[4]) |=> s_r.cnv_flag[4])
    else $error("converter edge lost");

  // [RULE_08] every converter edge sets its own flag
  AST_CNV_ALL: assert property ( // [RULE_08]
    (cnv_rise != '0) |=> ((s_r.cnv_flag & $past(cnv_rise)) == $past(cnv_rise)))
    else $error("comparator edge lost");

  // [RULE_11] every clock edge sets its own flag
  AST_RTC_EDGE: assert property ( // [RULE_11]
    (rtc_rise != '0) |=> ((s_r.rtc_flag & $past(rtc_rise)) == $past(rtc_rise)))
    else $error("clock edge lost");

  // [RULE_11] a held alarm level sets nothing again
  AST_RTC_LEVEL: assert property ( // [RULE_11]
    $rose(s_r.rtc_flag[0]) |-> $past(rtc_rise[0]))
    else $error("alarm flag set without rising edge");

  // [RULE_13] pin group tracks unmasked flags
  AST_PIN_IRQ: assert property ( // [RULE_13]
    pin_group_irq == |(s_r.pin_flag & ~s_r.pin_mask))
    else $error("pin group interrupt wrong");

  // [RULE_09] converter group tracks unmasked flags
  AST_CNV_IRQ: assert property ( // [RULE_09]
    converter_group_irq == |(s_r.cnv_flag & ~s_r.cnv_mask))
    else $error("converter group interrupt wrong");

  // [RULE_12] clock group tracks unmasked flags
  AST_RTC_IRQ: assert property ( // [RULE_12]
    rtc_group_irq == |(s_r.rtc_flag & ~s_r.rtc_mask))
    else $error("clock group interrupt wrong");

  // [RULE_05] all pin mask bits set keep the group low
  AST_PIN_MASKED: assert property ( // [RULE_05]
    (s_r.pin_mask == PIN_VALID) |-> !pin_group_irq)
    else $error("masked pin raised interrupt");

  // [RULE_07] converter bits appear at 8:4 of status two
  AST_CNV_MAP: assert property ( // [RULE_07]
    (arvalid && s_r.arready && f_ok(araddr) &&
     f_idx(araddr) == `GIA_IDX_STAT2) |=>
      (s_r.rdata[`GIA_CNV_HI:`GIA_CNV_LO] == $past(s_r.cnv_flag)))
    else $error("converter flags misplaced");

  // [RULE_10] clock bits appear at 7:5 of status one
  AST_RTC_MAP: assert property ( // [RULE_10]
    (arvalid && s_r.arready && f_ok(araddr) &&
     f_idx(araddr) == `GIA_IDX_STAT1) |=>
      (s_r.rdata[`GIA_RTC_HI:`GIA_RTC_LO] == $past(s_r.rtc_flag)))
    else $error("clock flags misplaced");

  // [RULE_01] any unmasked pin raises the common output
  AST_ANY_IRQ: assert property ( // [RULE_01]
    pin_group_irq |-> irq)
    else $error("pin interrupt not on common output");

  // [RULE_13] common line is exactly the or of the groups
  AST_IRQ_OR: assert property ( // [RULE_13]
    irq == (pin_group_irq || converter_group_irq || rtc_group_irq))
    else $error("common interrupt wrong");

  // write answer and its response code hold until taken
  AST_BHOLD: assert property (
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped early");

  // main scenarios
  COV_PIN_RD: cover property (rd_pin && s_r.pin_flag != '0);
  COV_CNV_IRQ: cover property ($rose(converter_group_irq));
  COV_RTC_IRQ: cover property ($rose(rtc_group_irq) ##[1:20] $fell(rtc_group_irq));
  COV_WR: cover property (bvalid && bready && bresp == `GIA_RESP_OKAY);
  COV_PIN_MASKED: cover property (s_r.pin_flag != '0 && !pin_group_irq);

endmodule // gia_irq_agg

// ===== gia_host_model.sv
// host-side AXI4-Lite master model for the aggregator register bus
`timescale 1ns/1ns

module gia_host_model (
  input  wire logic        clk,     // bus clock
  output logic [7:0]       awaddr,  // write address
  output logic             awvalid, // write address valid
  input  wire logic        awready, // write address ready
  output logic [31:0]      wdata,   // write data
  output logic [3:0]       wstrb,   // byte strobes
  output logic             wvalid,  // write data valid
  input  wire logic        wready,  // write data ready
  input  wire logic        bvalid,  // response valid
  output logic             bready,  // response ready
  output logic [7:0]       araddr,  // read address
  output logic             arvalid, // read address valid
  input  wire logic        arready, // read address ready
  input  wire logic        rvalid,  // read data valid
  output logic             rready   // read data ready
);
  // idle bus at time zero
  initial begin
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'hF;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
  end

  // one write; released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int slow, output bit ok);
    int n;
    n = 0;
    ok = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (slow == 0);
    while (!ok && n < 100) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid && bready) begin
        bready <= 1'b0;
        ok = 1;
      end else if (n >= slow) begin
        bready <= 1'b1;
      end
    end
  endtask

  // one read; slow delays rready to stretch the response
  task automatic rd(input logic [7:0] a, input int slow, output bit ok);
    int n;
    n = 0;
    ok = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= (slow == 0);
    while (!ok && n < 100) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid && rready) begin
        rready <= 1'b0;
        ok = 1;
      end else if (n >= slow) begin
        rready <= 1'b1;
      end
    end
  endtask
endmodule // gia_host_model

// ===== gia_irq_agg_tb.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ns
`include "gia_defs.svh"

module gia_irq_agg_tb;
  localparam logic [7:0] A_S1 = {`GIA_IDX_STAT1, 2'b00};
  localparam logic [7:0] A_S2 = {`GIA_IDX_STAT2, 2'b00};
  localparam logic [7:0] A_PS = {`GIA_IDX_PSTAT, 2'b00};
  localparam logic [7:0] A_M1 = {`GIA_IDX_MASK1, 2'b00};
  localparam logic [7:0] A_M2 = {`GIA_IDX_MASK2, 2'b00};
  localparam logic [7:0] A_PM = {`GIA_IDX_PMASK, 2'b00};
  localparam logic [1:0] OK   = `GIA_RESP_OKAY;
  localparam logic [1:0] SLV  = `GIA_RESP_SLV;
  logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pin_irq, cnv_irq, rtc_irq, irq;
  logic [12:0] pin_trig;
  logic [4:0]  conv_evt, cf, cm;
  logic [2:0]  rtc_evt, rf, rm;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] pf, pm;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          miscompares, total_checks;
  bit          ok;

  gia_irq_agg gia_irq_agg_i (.clk(clk), .nrst(nrst), .pin_trig(pin_trig), .conv_evt(conv_evt),
    .rtc_evt(rtc_evt), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_group_irq(pin_irq), .converter_group_irq(cnv_irq), .rtc_group_irq(rtc_irq), .irq(irq));

  gia_host_model gia_host_model_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hung handshake counts against the run and ends it
  task automatic bail();
    if (!ok) begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input int s);
    exp_r.push_back({r, d});
    gia_host_model_i.rd(a, s, ok);
    bail();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input int s);
    exp_b.push_back(r);
    gia_host_model_i.wr(a, d, s, ok);
    bail();
  endtask

  // reads all status words against the model, then the model forgets them
  task automatic rd_stat(input int s);
    rd(A_PS, {16'h0, pf}, OK, s);
    rd(A_S2, {23'h0, cf, 4'h0}, OK, s);
    rd(A_S1, {24'h0, rf, 5'h0}, OK, s);
    pf = 16'h0;
    cf = 5'h0;
    rf = 3'h0;
  endtask

  task automatic set_masks(input logic [12:0] p, input logic [4:0] c, input logic [2:0] r);
    pm = {3'h0, p};
    cm = c;
    rm = r;
    wr(A_PM, {16'h0, pm}, OK, 1);
    wr(A_M2, {23'h0, cm, 4'h0}, OK, 0);
    wr(A_M1, {24'h0, rm, 5'h0}, OK, 2);
    rd(A_PM, {16'h0, pm}, OK, 0);
    rd(A_M2, {23'h0, cm, 4'h0}, OK, 1);
    rd(A_M1, {24'h0, rm, 5'h0}, OK, 0);
  endtask

  // one-cycle event pulse on the given sources at once
  task automatic fire(input logic [12:0] p, input logic [4:0] c, input logic [2:0] r);
    @(posedge clk);
    pin_trig <= p;
    conv_evt <= c;
    rtc_evt  <= r;
    @(posedge clk);
    pin_trig <= 13'h0;
    conv_evt <= 5'h0;
    rtc_evt  <= 3'h0;
    pf[12:0] |= p;
    cf |= c;
    rf |= r;
    @(posedge clk);
  endtask

  // group lines follow flags and masks of the model
  task automatic chk_irq();
    logic [3:0] e;
    #1;
    e[3] = |(pf[12:0] & ~pm[12:0]);
    e[2] = |(cf & ~cm);
    e[1] = |(rf & ~rm);
    e[0] = |e[3:1];
    check({28'h0, pin_irq, cnv_irq, rtc_irq, irq}, {28'h0, e});
  endtask

  // result watcher: oldest note against each response handshake
  always @(posedge clk) begin
    logic [33:0] n;
    if (rvalid && rready) begin
      n = (exp_r.size() > 0) ? exp_r.pop_front() : ~{rresp, rdata};
      check({30'h0, rresp}, {30'h0, n[33:32]});
      check(rdata, n[31:0]);
    end
    if (bvalid && bready) begin
      n[1:0] = (exp_b.size() > 0) ? exp_b.pop_front() : ~bresp;
      check({30'h0, bresp}, {30'h0, n[1:0]});
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog against a stalled run
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    nrst = 1'b0;
    pin_trig = 13'h0;
    conv_evt = 5'h0;
    rtc_evt = 3'h0;
    {pf, pm, cf, cm, rf, rm} = '0;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(32'h696fc3f8));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // flags clear after reset; masks are then written to zero and read back
    rd_stat(1);
    set_masks(13'h0, 5'h0, 3'h0);
    chk_irq();
    // walk each flag position, second read must find it gone
    for (int i = 0; i < 13; i++) begin
      fire(13'h1 << i, (i < 5) ? 5'h1 << i : 5'h0, (i < 3) ? 3'h1 << i : 3'h0);
      chk_irq();
      rd_stat(i % 3);
      chk_irq();
      rd_stat(0);
    end
    // held-high level on edge sources sets each flag once only
    @(posedge clk);
    conv_evt <= 5'h1F;
    rtc_evt  <= 3'h7;
    repeat (3) @(posedge clk);
    cf = 5'h1F;
    rf = 3'h7;
    rd_stat(0);
    rd_stat(0);
    @(posedge clk);
    conv_evt <= 5'h0;
    rtc_evt  <= 3'h0;
    // random masks against random events
    for (int k = 0; k < 5; k++) begin
      set_masks(13'($urandom), 5'($urandom), 3'($urandom));
      fire(13'($urandom), 5'($urandom), 3'($urandom));
      chk_irq();
      rd_stat(k);
      chk_irq();
    end
    // everything masked, then unmasked while flags still stand
    set_masks(13'h1FFF, 5'h1F, 3'h7);
    fire(13'h1FFF, 5'h1F, 3'h7);
    chk_irq();
    set_masks(13'h0, 5'h0, 3'h0);
    chk_irq();
    rd_stat(2);
    chk_irq();
    // unmapped and misaligned places are refused without effect
    rd(8'h40, 32'h0, SLV, 0);
    rd(8'h85, 32'h0, SLV, 1);
    wr(8'h44, 32'hFFFF, SLV, 0);
    rd(A_PM, 32'h0, OK, 0);
    wrap_up();
  end
endmodule // gia_irq_agg_tb
